/* File: hw/sef_regs.svh */
// Purpose: Constants of the two-wire EEPROM front end
// Assumes: Included by the package and the front end module
// Notes:   Timing counts derive from the system clock period
`ifndef SEF_REGS_SVH
`define SEF_REGS_SVH

// ****************************************************************
// Array geometry
// ****************************************************************
`define SEF_ADDR_W        12
`define SEF_PAGE_W        5
`define SEF_ROW_W         7
`define SEF_MEM_BYTES     4096
`define SEF_PAGE_BYTES    32
`define SEF_PAGE_LAST     5'h1f

// ****************************************************************
// Bus word framing
// ****************************************************************
`define SEF_TYPE_CODE     4'ha
`define SEF_LAST_BIT      4'h7
`define SEF_ACK_SLOT      4'h8

// ****************************************************************
// Timing
// ****************************************************************
`define SEF_CLK_PERIOD_NS 10
`define SEF_WRITE_TIME_NS 5000000
`define SEF_PROG_CYCLES   (`SEF_WRITE_TIME_NS / `SEF_CLK_PERIOD_NS)
`define SEF_TMR_W         20

`endif

/* File: hw/sef_pkg.sv */
// Purpose: Types shared by the EEPROM front end
// Assumes: sef_regs.svh holds the geometry, framing and timing constants
// Notes:   Widths come from the header macros
`default_nettype none
`include "sef_regs.svh"

package sef_pkg;

  // ****************************************************************
  // Protocol states, Gray coded along the write path
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_DEVADR = 3'h1,
    ST_ADRHI  = 3'h3,
    ST_ADRLO  = 3'h2,
    ST_WDATA  = 3'h6,
    ST_RDATA  = 3'h7
  } sef_state_type;

  // Pin bundle as seen at the pads
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       wp;
    logic [2:0] cs;
  } sef_pins_type;

  // Link domain state
  typedef struct packed {
    sef_pins_type              pin_s1;
    sef_pins_type              pin_s2;
    logic                      scl_q;
    logic                      sda_q;
    sef_state_type             st;
    logic [3:0]                cnt;
    logic [7:0]                shreg;
    logic [`SEF_ADDR_W-1:0]    addr;
    logic [`SEF_ROW_W-1:0]     page;
    logic [7:0]                rd_byte;
    logic                      rw;
    logic                      ack_pend;
    logic                      oe;
    logic                      drv;
    logic                      busy;
    logic [`SEF_PAGE_BYTES-1:0] mask;
    logic                      committing;
    logic [`SEF_PAGE_W-1:0]    cidx;
    logic                      req_tgl;
    logic                      done_s1;
    logic                      done_s2;
    logic                      done_s3;
    logic                      standby;
  } sef_link_type;

  // System domain state: the write cycle timer
  typedef struct packed {
    logic                  req_s1;
    logic                  req_s2;
    logic                  req_s3;
    logic                  run;
    logic [`SEF_TMR_W-1:0] tmr;
    logic                  done_tgl;
  } sef_sys_type;

endpackage
`default_nettype wire

/* File: hw/sef_eeprom_front.sv */
// Purpose: Two-wire bus slave front end of a 4096 x 8 EEPROM
// Assumes: link_clk oversamples the bus pins; clk_sys times writes
// Notes:   Bus logic on link_clk, write timer on clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "sef_regs.svh"

module sef_eeprom_front #(
  parameter int unsigned PROG_CYCLES = `SEF_PROG_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic link_clk,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic chip_select_strap_2,
  input  wire logic chip_select_strap_1,
  input  wire logic chip_select_strap_0,
  input  wire logic write_protect,
  output logic      standby,
  output logic      prog_busy
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Pads pull open straps and write protect low before this point
  logic [7:0]             mem [`SEF_MEM_BYTES];
  logic [7:0]             pbuf [`SEF_PAGE_BYTES];
  logic                   mem_we;
  logic [`SEF_ADDR_W-1:0] mem_wa;
  logic [7:0]             mem_wd;
  logic                   pbuf_we;
  logic [`SEF_PAGE_W-1:0] pbuf_wa;
  logic [7:0]             pbuf_wd;

  sef_pkg::sef_link_type r;
  sef_pkg::sef_link_type next_r;
  sef_pkg::sef_sys_type  s;
  sef_pkg::sef_sys_type  next_s;
  sef_pkg::sef_pins_type pins_in;
  logic                  lrst_s1;
  logic                  link_rstn;

  // Pins gathered into one bundle
  assign pins_in = {scl_in, sda_in, write_protect,
                    chip_select_strap_2, chip_select_strap_1,
                    chip_select_strap_0};

  // ****************************************************************
  // Link domain reset
  // ****************************************************************
  // Reset follows rstn into link_clk via two stages
  always_ff @(posedge link_clk) begin
    lrst_s1   <= rstn;
    link_rstn <= lrst_s1;
  end

  // ****************************************************************
  // Bus condition detection
  // ****************************************************************
  logic       rise_ev;
  logic       fall_ev;
  logic       start_ev;
  logic       stop_ev;
  logic [7:0] byte_in;
  logic       dev_hit;

  // Edges seen on synchronised pins only
  assign rise_ev  = r.pin_s2.scl & ~r.scl_q;
  assign fall_ev  = ~r.pin_s2.scl & r.scl_q;
  // Data moving while clock is high is a condition, never a bit
  assign start_ev = r.pin_s2.scl & r.scl_q & r.sda_q &
                    ~r.pin_s2.sda;
  assign stop_ev  = r.pin_s2.scl & r.scl_q & ~r.sda_q &
                    r.pin_s2.sda;
  assign byte_in  = {r.shreg[6:0], r.pin_s2.sda};
  // Type code and strap match; refused outright while programming
  assign dev_hit  = (byte_in[7:4] == `SEF_TYPE_CODE) &&
                    (byte_in[3:1] == r.pin_s2.cs) &&
                    !r.busy;

  // ****************************************************************
  // Link next state
  // ****************************************************************
  // Protocol engine, page buffer and commit sequencer
  always_comb begin
    next_r         = r;
    next_r.pin_s1  = pins_in;
    next_r.pin_s2  = r.pin_s1;
    next_r.scl_q   = r.pin_s2.scl;
    next_r.sda_q   = r.pin_s2.sda;
    next_r.done_s1 = s.done_tgl;
    next_r.done_s2 = r.done_s1;
    next_r.done_s3 = r.done_s2;
    next_r.drv     = 1'b0;
    mem_we  = 1'b0;
    mem_wa  = '0;
    mem_wd  = 8'h00;
    pbuf_we = 1'b0;
    pbuf_wa = '0;
    pbuf_wd = 8'h00;

    // Timer done: copy buffered bytes into the array one per cycle
    if (r.done_s2 != r.done_s3) begin
      next_r.committing = 1'b1;
      next_r.cidx       = '0;
    end else if (r.committing) begin
      // Overwrite replaces old content, no separate erase
      mem_we      = r.mask[r.cidx];
      mem_wa      = {r.page, r.cidx};
      mem_wd      = pbuf[r.cidx];
      next_r.cidx = r.cidx + 5'h01;
      if (r.cidx == `SEF_PAGE_LAST) begin
        next_r.committing = 1'b0;
        next_r.busy       = 1'b0;
        next_r.mask       = '0;
      end
    end

    if (start_ev) begin
      // Any start restarts framing; covers the soft reset sequence
      next_r.st       = sef_pkg::ST_DEVADR;
      next_r.cnt      = 4'h0;
      next_r.ack_pend = 1'b0;
      next_r.oe       = 1'b0;
    end else if (stop_ev) begin
      // Programming only with data, protect low and no cycle running
      if (r.st == sef_pkg::ST_WDATA && |r.mask &&
          !r.pin_s2.wp && !r.busy) begin
        next_r.busy    = 1'b1;
        next_r.req_tgl = ~r.req_tgl;
      end
      next_r.st       = sef_pkg::ST_IDLE;
      next_r.oe       = 1'b0;
      next_r.ack_pend = 1'b0;
    end else if (rise_ev && r.st != sef_pkg::ST_IDLE) begin
      if (r.cnt != `SEF_ACK_SLOT) begin
        // Data bits latched on the rising clock
        next_r.shreg = byte_in;
        next_r.cnt   = r.cnt + 4'h1;
        if (r.cnt == `SEF_LAST_BIT) begin
          case (r.st)
            sef_pkg::ST_DEVADR: begin
              if (dev_hit) begin
                next_r.ack_pend = 1'b1;
                next_r.rw       = byte_in[0];
              end else begin
                next_r.st = sef_pkg::ST_IDLE;
              end
            end
            sef_pkg::ST_ADRHI: begin
              next_r.addr[11:8] = byte_in[3:0];
              next_r.ack_pend   = 1'b1;
              next_r.st         = sef_pkg::ST_ADRLO;
            end
            sef_pkg::ST_ADRLO: begin
              next_r.addr[7:0] = byte_in;
              next_r.page      = {r.addr[11:8], byte_in[7:5]};
              next_r.mask      = '0;
              next_r.ack_pend  = 1'b1;
              next_r.st        = sef_pkg::ST_WDATA;
            end
            sef_pkg::ST_WDATA: begin
              // Bytes held until the cycle ends, array untouched
              pbuf_we = 1'b1;
              pbuf_wa = r.addr[4:0];
              pbuf_wd = byte_in;
              next_r.mask[r.addr[4:0]] = 1'b1;
              next_r.addr[4:0] = r.addr[4:0] + 5'h01;
              next_r.ack_pend  = 1'b1;
            end
            sef_pkg::ST_RDATA: begin
              // Counter wraps at the top of the array
              next_r.addr = r.addr + 12'h001;
            end
            default: begin
              next_r.st = sef_pkg::ST_IDLE;
            end
          endcase
        end
      end else begin
        // Ninth clock: our acknowledge, or the master's on reads
        next_r.cnt      = 4'h0;
        next_r.ack_pend = 1'b0;
        case (r.st)
          sef_pkg::ST_DEVADR: begin
            if (r.rw) begin
              next_r.st      = sef_pkg::ST_RDATA;
              next_r.rd_byte = mem[r.addr];
            end else begin
              next_r.st = sef_pkg::ST_ADRHI;
            end
          end
          sef_pkg::ST_RDATA: begin
            if (r.pin_s2.sda) begin
              next_r.st = sef_pkg::ST_IDLE;
            end else begin
              next_r.rd_byte = mem[r.addr];
            end
          end
          default: begin
            next_r.st = r.st;
          end
        endcase
      end
    end else if (fall_ev && r.st != sef_pkg::ST_IDLE) begin
      // Output changes only after the falling clock
      if (r.cnt == `SEF_ACK_SLOT) begin
        next_r.oe = r.ack_pend;
      end else if (r.st == sef_pkg::ST_RDATA) begin
        next_r.oe = ~r.rd_byte[3'(`SEF_LAST_BIT - r.cnt)];
      end else begin
        next_r.oe = 1'b0;
      end
    end

    next_r.standby = (next_r.st == sef_pkg::ST_IDLE) &&
                     !next_r.busy;
  end

  // ****************************************************************
  // Link registers and arrays
  // ****************************************************************
  // Power-up lands in standby with the line released
  always_ff @(posedge link_clk) begin
    if (!link_rstn) begin
      r         <= '0;
      r.standby <= 1'b1;
      // Idle bus levels, so no false edge follows reset
      r.pin_s1.scl <= 1'b1;
      r.pin_s1.sda <= 1'b1;
      r.pin_s2.scl <= 1'b1;
      r.pin_s2.sda <= 1'b1;
      r.scl_q      <= 1'b1;
      r.sda_q      <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Array and page buffer write ports, no reset on storage
  always_ff @(posedge link_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (pbuf_we) begin
      pbuf[pbuf_wa] <= pbuf_wd;
    end
  end

  // ****************************************************************
  // Write cycle timer on clk_sys
  // ****************************************************************
  // Request arrives as a toggle; done returns as a toggle
  always_comb begin
    next_s        = s;
    next_s.req_s1 = r.req_tgl;
    next_s.req_s2 = s.req_s1;
    next_s.req_s3 = s.req_s2;
    if (s.req_s2 != s.req_s3) begin
      next_s.run = 1'b1;
      next_s.tmr = '0;
    end else if (s.run) begin
      next_s.tmr = s.tmr + 20'h00001;
      if (s.tmr == 20'(PROG_CYCLES - 1)) begin
        next_s.run      = 1'b0;
        next_s.done_tgl = ~s.done_tgl;
      end
    end
  end

  // Timer state
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Each output is a field of the link state register
  assign sda_out   = r.drv;
  assign sda_oe    = r.oe;
  assign standby   = r.standby;
  assign prog_busy = r.busy;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence seq_dev_end;
    rise_ev && r.st == sef_pkg::ST_DEVADR && r.cnt == 4'h7;
  endsequence

  sequence seq_wdata_end;
    rise_ev && r.st == sef_pkg::ST_WDATA && r.cnt == 4'h7;
  endsequence

  chk_oe_on_fall: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    $changed(sda_oe) |-> $past(fall_ev || start_ev || stop_ev))
    else $error("data line changed outside a falling clock");

  chk_open_drain_low: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    sda_out == 1'b0)
    else $error("data line driven high");

  chk_wp_blocks_prog: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    (stop_ev && r.pin_s2.wp) |=> !$rose(prog_busy))
    else $error("programming started under write protect");

  chk_start_to_addr: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    start_ev |=> r.st == sef_pkg::ST_DEVADR && !sda_oe)
    else $error("start did not restart framing");

  chk_stop_to_idle: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    stop_ev |=> r.st == sef_pkg::ST_IDLE && !sda_oe)
    else $error("stop did not end the command");

  chk_match_acks: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    (seq_dev_end and dev_hit) |=> r.ack_pend && r.cnt == 4'h8)
    else $error("matching address not acknowledged");

  chk_ack_drive: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    (fall_ev && r.cnt == 4'h8 && r.ack_pend &&
     r.st != sef_pkg::ST_IDLE && !start_ev && !stop_ev) |=> sda_oe)
    else $error("acknowledge not driven on ninth clock");

  chk_busy_no_ack: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    (seq_dev_end and r.busy) |=> r.st == sef_pkg::ST_IDLE && !r.ack_pend)
    else $error("address acknowledged while programming");

  chk_page_wrap: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    seq_wdata_end |=> r.addr[11:5] == $past(r.addr[11:5]) &&
      r.addr[4:0] == $past(r.addr[4:0]) + 5'h01)
    else $error("page write address left its page");

  chk_idle_release: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    r.st == sef_pkg::ST_IDLE |-> !sda_oe)
    else $error("data line held while idle");

  chk_timer_bound: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    s.run |-> s.tmr < 20'(PROG_CYCLES))
    else $error("write cycle ran past its limit");

endmodule
`default_nettype wire

/* File: verification/sef_bus_master.sv */
// Purpose: Behavioural two-wire bus master for the EEPROM front end
// Assumes: SDA has a pull-up in the bench; SCL rests high between frames
// Notes:   Phase length in link_clk cycles; data moves with SCL low except in start and stop
`timescale 1ns/1ps
`default_nettype none

module sef_bus_master #(
  parameter int unsigned PH = 6
) (
  input  wire logic link_clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_oe
);
  // ****************************************************************
  // Bus conditions and bits
  // ****************************************************************
  // Idle bus: clock high, data released
  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end

  // One phase; long enough that the device answer lands well inside it
  task automatic ph();
    repeat (PH) @(posedge link_clk);
  endtask

  // Start, also usable as repeated start from SCL low
  task automatic bus_start();
    sda_oe <= 1'b0;
    ph();
    scl <= 1'b1;
    ph();
    sda_oe <= 1'b1;
    ph();
    scl <= 1'b0;
    ph();
  endtask

  // Stop: data rises while SCL high
  task automatic bus_stop();
    sda_oe <= 1'b1;
    ph();
    scl <= 1'b1;
    ph();
    sda_oe <= 1'b0;
    ph();
  endtask

  // Data set with SCL low, sampled late in the high phase
  task automatic bus_bit(input logic b, output logic got);
    sda_oe <= ~b;
    ph();
    scl <= 1'b1;
    ph();
    got = sda_in;
    scl <= 1'b0;
    ph();
  endtask

  // Eight bits MSB first, then the answer bit
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bus_bit(d[i], g);
    bus_bit(1'b1, g);
    ack = ~g;
  endtask

  // Read one byte, then acknowledge or not
  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(1'b1, g);
      d[i] = g;
    end
    bus_bit(~ack, g);
  endtask
endmodule
`default_nettype wire

/* File: verification/sef_eeprom_front_bench.sv */
// Purpose: Self-checking bench of the EEPROM front end
// Assumes: Short write time parameter; bus master model drives SCL/SDA
// Notes:   Expected array contents kept only for locations written
`timescale 1ns/1ps
`default_nettype none

module sef_eeprom_front_bench;
  localparam int unsigned PROG = 400;
  logic       clk_sys, link_clk, rstn, wp, sda_out, sda_oe;
  logic       standby, prog_busy, scl, m_oe, sda, oe_q;
  logic [2:0] cs;
  int         err_count, num_checks;
  logic [7:0] exp_mem [int];

  // Wired data line with pull-up
  assign sda = ~((sda_oe & ~sda_out) | m_oe);

  sef_eeprom_front #(.PROG_CYCLES(PROG)) sef_eeprom_front_inst (
    .clk_sys(clk_sys), .rstn(rstn), .link_clk(link_clk), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_strap_2(cs[2]), .chip_select_strap_1(cs[1]),
    .chip_select_strap_0(cs[0]), .write_protect(wp),
    .standby(standby), .prog_busy(prog_busy));

  sef_bus_master #(.PH(6)) sef_bus_master_inst (
    .link_clk(link_clk), .sda_in(sda), .scl(scl), .sda_oe(m_oe));

  // ****************************************************************
  // Clocks, checking and closing
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Odd offset keeps the link clock out of phase with clk_sys
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Drive changes only with SCL low, and only ever pulls low
  always @(posedge link_clk) begin
    if (rstn === 1'b1 && sda_oe !== oe_q) check("oe_scl", scl, 1'b0);
    if (sda_oe === 1'b1) check("drive_low", sda_out, 1'b0);
    oe_q <= sda_oe;
  end

  // Hang guard: span well beyond the planned traffic
  initial begin
    #900000;
    err_count++;
    wrap_up();
  end

  // ****************************************************************
  // Transfer tasks
  // ****************************************************************
  // Byte position inside the page after i data bytes
  function automatic int page_pos(input logic [11:0] a, input int i);
    return int'({a[11:5], a[4:0] + 5'(i)});
  endfunction

  task automatic dev_word(input logic [2:0] s, input logic rw,
                          output logic ack);
    sef_bus_master_inst.bus_start();
    sef_bus_master_inst.put_byte({4'ha, s, rw}, ack);
  endtask

  task automatic set_addr(input logic [11:0] a);
    logic ack;
    dev_word(cs, 1'b0, ack);
    check("dev_ack", ack, 1'b1);
    sef_bus_master_inst.put_byte({4'h0, a[11:8]}, ack);
    check("hi_ack", ack, 1'b1);
    sef_bus_master_inst.put_byte(a[7:0], ack);
    check("lo_ack", ack, 1'b1);
  endtask

  task automatic read_seq(input logic [11:0] a, input int n);
    logic       ack;
    logic [7:0] d;
    int         p;
    set_addr(a);
    dev_word(cs, 1'b1, ack);
    check("rd_ack", ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      p = int'(12'(a + 12'(i)));  // Wraps like the address counter
      sef_bus_master_inst.get_byte(i < n - 1, d);
      if (exp_mem.exists(p)) check("rd_data", d, exp_mem[p]);
    end
    sef_bus_master_inst.bus_stop();
    repeat (4) @(posedge link_clk);
    check("rd_standby", standby, 1'b1);
  endtask

  // Write n random bytes, wait out programming, read the whole page
  task automatic wr_test(input logic [11:0] a, input int n);
    logic       ack;
    logic [7:0] d;
    int         t;
    time        t0;
    set_addr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      sef_bus_master_inst.put_byte(d, ack);
      check("data_ack", ack, 1'b1);
      if (wp === 1'b0) exp_mem[page_pos(a, i)] = d;
    end
    sef_bus_master_inst.bus_stop();
    t0 = $time;
    repeat (10) @(posedge link_clk);
    if (wp === 1'b0) begin
      check("busy_on", prog_busy, 1'b1);
      check("standby_off", standby, 1'b0);
      dev_word(cs, 1'b1, ack);
      check("poll_nack", ack, 1'b0);
      sef_bus_master_inst.bus_stop();
      t = 0;
      while (prog_busy !== 1'b0 && t < 2000) begin
        @(posedge clk_sys);
        t++;
      end
      check("prog_time", ($time - t0) < (PROG + 100) * 10, 1'b1);
      repeat (4) @(posedge link_clk);
      check("standby_on", standby, 1'b1);
    end else begin
      check("wp_no_busy", prog_busy, 1'b0);
    end
    read_seq({a[11:5], 5'h00}, 32);
    $display("test write %h len %0d wp %b done", a, n, wp);
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    logic       ack;
    logic [7:0] d;
    logic [11:0] a;
    rstn = 1'b0;
    wp = 1'b0;
    cs = 3'h0;
    err_count = 0;
    num_checks = 0;
    void'($urandom(32'hfe5a));
    repeat (10) @(posedge clk_sys);
    check("rst_standby", standby, 1'b1);
    check("rst_busy", prog_busy, 1'b0);
    check("rst_oe", sda_oe, 1'b0);
    rstn <= 1'b1;
    cs <= 3'($urandom);
    repeat (10) @(posedge link_clk);
    // Wrong type code and wrong straps are both refused
    for (int i = 0; i < 4; i++) begin
      sef_bus_master_inst.bus_start();
      sef_bus_master_inst.put_byte({4'ha ^ 4'(i + 1), cs, 1'b0}, ack);
      check("type_nack", ack, 1'b0);
      dev_word(cs ^ 3'(i + 1), 1'b0, ack);
      check("strap_nack", ack, 1'b0);
      sef_bus_master_inst.bus_stop();
    end
    $display("test refusals done");
    // Overlong page write wraps inside the page
    wr_test({7'($urandom), 5'h1e}, 34);
    for (int i = 0; i < 2; i++) begin
      a = 12'($urandom);
      wr_test(a, 1 + int'($urandom % 32));
    end
    // Protected write leaves the page as it was
    @(posedge clk_sys) wp <= 1'b1;
    wr_test(a, 5);
    @(posedge clk_sys) wp <= 1'b0;
    // Read counter wraps from the top address to zero
    wr_test(12'hffe, 2);
    wr_test(12'h000, 2);
    read_seq(12'hffe, 4);
    $display("test address wrap done");
    // Interrupted command, then start, eighteen ones, start
    dev_word(cs, 1'b0, ack);
    sef_bus_master_inst.put_byte(8'h0f, ack);
    sef_bus_master_inst.bus_start();
    for (int i = 0; i < 18; i++) sef_bus_master_inst.bus_bit(1'b1, ack);
    dev_word(cs, 1'b1, ack);
    check("soft_rst_ack", ack, 1'b1);
    sef_bus_master_inst.get_byte(1'b0, d);
    sef_bus_master_inst.bus_stop();
    $display("test soft reset done");
    // Straps left low answer to address bits of zero
    @(posedge clk_sys) cs <= 3'h0;
    repeat (10) @(posedge link_clk);
    dev_word(3'h0, 1'b1, ack);
    check("strap_low_ack", ack, 1'b1);
    sef_bus_master_inst.get_byte(1'b0, d);
    sef_bus_master_inst.bus_stop();
    $display("test low straps done");
    wrap_up();
  end
endmodule
`default_nettype wire
